// ### fdcw_defines.vh
// Purpose: Constants for the floppy write/format command decoder.
// Assumes: 8-bit data port, 20 MHz clock.
// Notes:   Included by both design files.
`ifndef FDCW_DEFINES_VH
`define FDCW_DEFINES_VH
// ---------------------------------------------------------------
// Command codes (low bits for write and format, whole byte for the rest)
// ---------------------------------------------------------------
`define FDCW_OP_WRITE      5'h05
`define FDCW_OP_WRITE_DEL  5'h09
`define FDCW_OP_FORMAT     6'h0D
`define FDCW_OP_RECAL      8'h07
`define FDCW_OP_SENSE      8'h08
`define FDCW_OP_SPECIFY    8'h03
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FDCW_MULTI_TRACK_BIT 7
`define FDCW_DENS_BIT      6
`define FDCW_HEAD_BIT      2
// ---------------------------------------------------------------
// Byte counts and values
// ---------------------------------------------------------------
`define FDCW_WRITE_BYTES   4'h9
`define FDCW_FORMAT_BYTES  4'h6
`define FDCW_RECAL_BYTES   4'h2
`define FDCW_SPEC_BYTES    4'h3
`define FDCW_WRITE_RES     4'h7
`define FDCW_SENSE_RES     4'h2
`define FDCW_INVALID_RES   4'h1
`define FDCW_INVALID_STAT  8'h80
`define FDCW_SEEK_END_STAT 8'h20
`define FDCW_UNDEF_BYTE    8'h00
// ---------------------------------------------------------------
// Timing: one step pulse every STEP_NS nanoseconds.
// ---------------------------------------------------------------
`define FDCW_CLK_MHZ       20
`define FDCW_STEP_NS       1000
`define FDCW_STEP_CYC      ((`FDCW_STEP_NS * `FDCW_CLK_MHZ) / 1000)
`endif

// ### fdcw_step_gen.v
// Purpose: Divider producing one-cycle step strobes while enabled.
// Assumes: Single clock; synchronous active-low reset.
// Notes:   Count restarts whenever enable drops.
`timescale 1ns/1ns
`include "fdcw_defines.vh"
module fdcw_step_gen
(
    input  wire i_clk,     // System clock.
    input  wire i_rst_n,   // Synchronous reset, active low.
    input  wire i_en,      // Stepping requested.
    output reg  o_tick     // One-cycle strobe per step period.
);
    // ---------------------------------------------------------------
    // Period counter
    // ---------------------------------------------------------------
    // Worked out as an integer, then cut to the counter width on purpose.
    localparam integer LAST_INT = `FDCW_STEP_CYC - 1;
    localparam [15:0]  LAST     = LAST_INT[15:0];
    reg [15:0] cnt;        // Cycles elapsed in this period.

    // Count while enabled and pulse in the cycle after the count reaches LAST.
    always @(posedge i_clk)
    begin
        if (!i_rst_n || !i_en)
        begin
            cnt    <= 16'h0000;
            o_tick <= 1'b0;
        end
        else if (cnt == LAST)
        begin
            cnt    <= 16'h0000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt    <= cnt + 16'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule // fdcw_step_gen

// ### fdcw_cmd_decoder.v
// Purpose: Command, execution and result sequencing for write data,
//          write deleted data, format, recalibrate, sense interrupt
//          status and specify.
// Assumes: Host strobes are synchronous to i_clk; the track-zero pin
//          is asynchronous and is synchronised here.
// Notes:   Sector data moves on a simple byte strobe pair; the media
//          itself is outside this block.
`timescale 1ns/1ns
`include "fdcw_defines.vh"
// Overview of operation
// - Write: code xx00101, nine bytes, data moves
// - Deleted write: code xx01001, same nine bytes
// - Writes return status bytes and CHRN
// - Format: six bytes, per-sector CHRN, seven results
// - Recalibrate steps to track zero, then interrupts
// - Sense interrupt returns status zero, cylinder
// - Unknown code: no operation, result 80H
module fdcw_cmd_decoder
(
    input  wire       i_clk,          // System clock, 20 MHz.
    input  wire       i_rst_n,        // Synchronous reset, active low.
    input  wire       i_wr,           // Host writes a byte, one cycle.
    input  wire [7:0] i_wdata,        // Byte written by the host.
    input  wire       i_rd,           // Host takes a result byte.
    output reg  [7:0] o_rdata,        // Result byte on offer.
    output wire       o_rd_valid,     // Result byte is on offer.
    output wire       o_cmd_busy,     // Not idle.
    output wire       o_exec,         // Execution phase in progress.
    output wire       o_data_req,     // Execution wants a data byte.
    output reg  [7:0] o_data_out,     // Data byte passed to the drive.
    output reg        o_data_stb,     // Data byte strobe to the drive.
    output reg        o_interrupt,    // Interrupt request, level.
    output reg  [1:0] o_drive_sel,    // Selected drive.
    output reg        o_head_select,  // Selected head.
    output reg        o_multi_track_flag,
    output reg        o_density_select_flag,
    output reg        o_deleted_mark, // Write carries deleted mark.
    output reg  [3:0] o_step_rate_time,
    output reg  [3:0] o_head_unload_time,
    output reg  [6:0] o_head_load_time,
    output reg        o_no_dma_select,
    output wire       o_step,         // Step pulse toward track zero.
    input  wire       i_track0,       // Head at track zero, async pin.
    input  wire       i_exec_done     // Media layer ends the transfer.
);
    // ---------------------------------------------------------------
    // Phases and command kinds
    // ---------------------------------------------------------------
    localparam [1:0] PH_IDLE = 2'h0, PH_CMD = 2'h1,
                     PH_EXEC = 2'h2, PH_RES = 2'h3;
    localparam [2:0] K_WRITE = 3'h0, K_FORMAT = 3'h1, K_RECAL = 3'h2,
                     K_SENSE = 3'h3, K_SPEC = 3'h4, K_BAD = 3'h5;

    reg  [1:0] phase;                // Current phase.
    reg  [2:0] kind;                 // Command being run.
    reg  [3:0] idx;                  // Byte index within the phase.
    reg  [3:0] need;                 // Bytes in command or result.
    reg  [7:0] prm [0:8];            // Command bytes as received.
    reg  [1:0] fmt_cnt;              // CHRN position while formatting.
    reg  [7:0] fmt_left;             // Sectors still to be formatted.
    reg  [7:0] cyl;                  // Present cylinder.
    reg        irq_pend;             // Seek end awaits a sense.
    reg  [7:0] irq_stat;             // Status zero for that sense.
    reg        t0_a, t0_b;           // Track-zero synchroniser.
    wire       tick;                 // Step strobe from divider.
    integer    i;

    // Decode a first byte into a command kind and its byte count.
    function [6:0] decode;
        input [7:0] b;
        begin
            if (b[4:0] == `FDCW_OP_WRITE || b[4:0] == `FDCW_OP_WRITE_DEL)
                decode = {K_WRITE, `FDCW_WRITE_BYTES};
            else if (!b[7] && b[5:0] == `FDCW_OP_FORMAT)
                decode = {K_FORMAT, `FDCW_FORMAT_BYTES};
            else if (b == `FDCW_OP_RECAL)
                decode = {K_RECAL, `FDCW_RECAL_BYTES};
            else if (b == `FDCW_OP_SENSE)
                decode = {K_SENSE, 4'h1};
            else if (b == `FDCW_OP_SPECIFY)
                decode = {K_SPEC, `FDCW_SPEC_BYTES};
            else
                decode = {K_BAD, 4'h1};
        end
    endfunction

    assign o_cmd_busy = (phase != PH_IDLE);
    assign o_exec     = (phase == PH_EXEC);
    assign o_rd_valid = (phase == PH_RES);
    assign o_data_req = o_exec && (kind == K_WRITE || kind == K_FORMAT);
    assign o_step     = tick;

    // ---------------------------------------------------------------
    // Step divider, running only during recalibrate off track zero.
    // ---------------------------------------------------------------
    fdcw_step_gen u_step
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_en    (o_exec && kind == K_RECAL && !t0_b),
        .o_tick  (tick)
    );

    // Track-zero pin passes two flip-flops before use.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            t0_a <= 1'b0;
            t0_b <= 1'b0;
        end
        else
        begin
            t0_a <= i_track0;
            t0_b <= t0_a;
        end
    end

    // Result byte selection from the kind and index.
    always @*
    begin
        o_rdata = `FDCW_UNDEF_BYTE;
        case (kind)
            K_WRITE:
                case (idx)
                    4'h0: o_rdata = {5'h00, prm[1][2:0]};
                    4'h1: o_rdata = 8'h00;
                    4'h2: o_rdata = 8'h00;
                    4'h3: o_rdata = prm[2];
                    4'h4: o_rdata = prm[3];
                    4'h5: o_rdata = prm[4];
                    default: o_rdata = prm[5];
                endcase
            K_FORMAT:
                o_rdata = (idx == 4'h0) ? {5'h00, prm[1][2:0]}
                                        : `FDCW_UNDEF_BYTE;
            K_SENSE:
                o_rdata = (idx == 4'h0) ? irq_stat : cyl;
            K_BAD:   o_rdata = `FDCW_INVALID_STAT;
            default: o_rdata = `FDCW_UNDEF_BYTE;
        endcase
        // Outside the result phase the port rests at zero, so a stale
        // command kind never shows through after reset.
        if (!o_rd_valid)
            o_rdata = `FDCW_UNDEF_BYTE;
    end

    // ---------------------------------------------------------------
    // Phase sequencer.
    // ---------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            phase <= PH_IDLE;
            kind  <= K_BAD;
            idx   <= 4'h0;
            need  <= 4'h0;
            for (i = 0; i < 9; i = i + 1)
                prm[i] <= 8'h00;
            fmt_cnt  <= 2'h0;
            fmt_left <= 8'h00;
            cyl      <= 8'h00;
            irq_pend <= 1'b0;
            irq_stat <= 8'h00;
            o_interrupt <= 1'b0;
            o_drive_sel <= 2'h0;
            o_head_select <= 1'b0;
            o_multi_track_flag <= 1'b0;
            o_density_select_flag <= 1'b0;
            o_deleted_mark <= 1'b0;
            o_step_rate_time <= 4'h0;
            o_head_unload_time <= 4'h0;
            o_head_load_time <= 7'h00;
            o_no_dma_select <= 1'b0;
            o_data_out <= 8'h00;
            o_data_stb <= 1'b0;
        end
        else
        begin
            o_data_stb <= 1'b0;
            case (phase)
                PH_IDLE:
                    if (i_wr)
                    begin
                        prm[0] <= i_wdata;
                        {kind, need} <= decode(i_wdata);
                        o_multi_track_flag <= i_wdata[`FDCW_MULTI_TRACK_BIT];
                        o_density_select_flag <= i_wdata[`FDCW_DENS_BIT];
                        // Only the deleted-mark write raises the mark.
                        o_deleted_mark <=
                            (i_wdata[4:0] == `FDCW_OP_WRITE_DEL);
                        idx <= 4'h1;
                        phase <= PH_CMD;
                    end
                PH_CMD:
                    if (idx >= need)
                    begin
                        // All command bytes in; act on the command.
                        idx <= 4'h0;
                        case (kind)
                            K_WRITE, K_RECAL:
                                phase <= PH_EXEC;
                            K_FORMAT:
                            begin
                                fmt_left <= prm[3];
                                fmt_cnt  <= 2'h0;
                                phase    <= PH_EXEC;
                            end
                            K_SENSE:
                            begin
                                // Sense also drops the interrupt.
                                o_interrupt <= 1'b0;
                                irq_pend <= 1'b0;
                                if (!irq_pend)
                                    irq_stat <= `FDCW_INVALID_STAT;
                                need  <= `FDCW_SENSE_RES;
                                phase <= PH_RES;
                            end
                            K_SPEC:
                            begin
                                o_step_rate_time   <= prm[1][7:4];
                                o_head_unload_time <= prm[1][3:0];
                                o_head_load_time   <= prm[2][7:1];
                                o_no_dma_select    <= prm[2][0];
                                phase <= PH_IDLE;
                            end
                            default:
                            begin
                                need  <= `FDCW_INVALID_RES;
                                phase <= PH_RES;
                            end
                        endcase
                    end
                    else if (i_wr)
                    begin
                        prm[idx] <= i_wdata;
                        idx <= idx + 4'h1;
                        if (idx == 4'h1)
                        begin
                            o_drive_sel <= i_wdata[1:0];
                            o_head_select <= (kind != K_RECAL) &&
                                             i_wdata[`FDCW_HEAD_BIT];
                        end
                    end
                PH_EXEC:
                    case (kind)
                        K_RECAL:
                            if (t0_b)
                            begin
                                cyl <= 8'h00;
                                irq_stat <= `FDCW_SEEK_END_STAT |
                                            {6'h00, o_drive_sel};
                                irq_pend <= 1'b1;
                                o_interrupt <= 1'b1;
                                phase <= PH_IDLE;
                            end
                        K_FORMAT:
                            if (fmt_left == 8'h00 || i_exec_done)
                            begin
                                need  <= `FDCW_WRITE_RES;
                                phase <= PH_RES;
                            end
                            else if (i_wr)
                            begin
                                // Sector CHRN bytes go to the drive.
                                o_data_out <= i_wdata;
                                o_data_stb <= 1'b1;
                                fmt_cnt <= fmt_cnt + 2'h1;
                                if (fmt_cnt == 2'h3)
                                    fmt_left <= fmt_left - 8'h01;
                            end
                        default:
                            if (i_exec_done)
                            begin
                                need  <= `FDCW_WRITE_RES;
                                phase <= PH_RES;
                            end
                            else if (i_wr)
                            begin
                                o_data_out <= i_wdata;
                                o_data_stb <= 1'b1;
                            end
                    endcase
                default:
                    if (i_rd)
                    begin
                        if (idx + 4'h1 >= need)
                        begin
                            idx   <= 4'h0;
                            phase <= PH_IDLE;
                        end
                        else
                            idx <= idx + 4'h1;
                    end
            endcase
        end
    end
endmodule // fdcw_cmd_decoder

// ### fdcw_cmd_props.sv
// Purpose: Concurrent checks on the command decoder ports.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Sees only the top module ports; bound below.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Checker
// ---------------------------------------------------------------
module fdcw_cmd_props
(
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rd_valid,
    input wire logic       o_cmd_busy,
    input wire logic       o_exec,
    input wire logic       o_data_req,
    input wire logic [7:0] o_data_out,
    input wire logic       o_data_stb,
    input wire logic       o_interrupt,
    input wire logic       o_step
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // An unknown command byte taken while idle.
    sequence s_bad_cmd;
        !o_cmd_busy && i_wr && i_wdata == 8'hFF;
    endsequence
    // A write command byte taken while idle.
    sequence s_write_cmd;
        !o_cmd_busy && i_wr && i_wdata[4:0] == 5'h05;
    endsequence
    a_reset_quiet: assert property (
        $rose(i_rst_n) |-> !o_cmd_busy && !o_rd_valid && !o_interrupt)
        else $error("outputs not quiet after reset");
    a_write_count: assert property (
        s_write_cmd |=> !o_exec[*8])
        else $error("write executes before nine bytes");
    a_bad_answer: assert property (
        s_bad_cmd |=> ##[1:2] (o_rd_valid && o_rdata == 8'h80))
        else $error("unknown code gave no 80 result");
    a_no_overlap: assert property (
        !(o_exec && o_rd_valid))
        else $error("execution and result phase together");
    a_rd_stands: assert property (
        o_rd_valid && !i_rd |=> o_rd_valid && $stable(o_rdata))
        else $error("result byte changed before it was taken");
    a_stb_cause: assert property (
        o_data_stb |-> $past(i_wr) && o_data_out == $past(i_wdata))
        else $error("data strobe without matching host byte");
    a_step_cause: assert property (
        o_step |-> o_exec && !o_data_req)
        else $error("step pulse outside recalibrate");
    a_step_gap: assert property (
        $rose(o_step) |=> !o_step[*8])
        else $error("step pulses too close together");
    a_irq_holds: assert property (
        o_interrupt && !o_cmd_busy && !i_wr |=> o_interrupt)
        else $error("interrupt dropped without a query");
endmodule // fdcw_cmd_props

bind fdcw_cmd_decoder fdcw_cmd_props u_props (.i_clk, .i_rst_n,
    .i_wr, .i_wdata, .i_rd, .o_rdata, .o_rd_valid, .o_cmd_busy,
    .o_exec, .o_data_req, .o_data_out, .o_data_stb, .o_interrupt,
    .o_step);

// ### fdcw_drive_model.sv
// Purpose: Behavioural drive: track-zero sensor and media end.
// Assumes: Same clock as the decoder.
// Notes:   Quota zero means the media never ends a transfer.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Drive model
// ---------------------------------------------------------------
module fdcw_drive_model
#(
    parameter STEPS = 3            // Steps from start to track zero.
)
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_step,
    input  wire logic       i_stb,
    input  wire logic       i_exec,
    input  wire logic [3:0] i_quota,
    output logic            o_track0 = 1'b0,
    output logic            o_exec_done = 1'b0,
    output logic [7:0]      o_steps = 8'h00
);
    logic [3:0] cnt = 4'h0;        // Data bytes seen in this transfer.
    // The sensor trips only once enough steps arrived, so a decoder
    // that stops early or late is seen in the step count.
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_track0    <= 1'b0;
            o_exec_done <= 1'b0;
            o_steps     <= 8'h00;
            cnt         <= 4'h0;
        end
        else
        begin
            o_steps  <= o_steps + {7'h00, i_step};
            o_track0 <= o_track0 | (i_step && o_steps == STEPS - 1);
            cnt      <= i_exec ? cnt + {3'h0, i_stb} : 4'h0;
            o_exec_done <= i_exec && i_stb && i_quota != 4'h0 &&
                           cnt == i_quota - 4'h1;
        end
    end
endmodule // fdcw_drive_model

// ### fdcw_cmd_decoder_bench.sv
// Purpose: Self-checking bench for the command decoder.
// Assumes: Host bytes driven on rising edges, sampled at falling.
// Notes:   Write cases come from a table; the rest are by hand.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Bench
// ---------------------------------------------------------------
module fdcw_cmd_decoder_bench;
    logic       i_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       i_wr = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_rd = 1'b0;
    logic [3:0] quota = 4'h2;      // Bytes before the media ends.
    wire  [7:0] o_rdata, o_data_out, steps;
    wire  [3:0] o_step_rate_time, o_head_unload_time;
    wire  [6:0] o_head_load_time;
    wire  [1:0] o_drive_sel;
    wire        o_rd_valid, o_cmd_busy, o_exec, o_data_req, o_data_stb;
    wire        o_interrupt, o_head_select, o_multi_track_flag;
    wire        o_density_select_flag, o_deleted_mark, o_no_dma_select;
    wire        o_step, i_track0, i_exec_done;
    integer     errors = 0, n_checks = 0, cyc = 0, k;
    logic [23:0] rows [0:3];       // Command, drive byte, status zero.
    always #25 i_clk = ~i_clk;
    fdcw_cmd_decoder dut (.i_clk, .i_rst_n, .i_wr, .i_wdata, .i_rd,
        .o_rdata, .o_rd_valid, .o_cmd_busy, .o_exec, .o_data_req,
        .o_data_out, .o_data_stb, .o_interrupt, .o_drive_sel,
        .o_head_select, .o_multi_track_flag, .o_density_select_flag,
        .o_deleted_mark, .o_step_rate_time, .o_head_unload_time,
        .o_head_load_time, .o_no_dma_select, .o_step, .i_track0,
        .i_exec_done);
    fdcw_drive_model drv (.i_clk, .i_rst_n, .i_step(o_step),
        .i_stb(o_data_stb), .i_exec(o_exec), .i_quota(quota),
        .o_track0(i_track0), .o_exec_done(i_exec_done), .o_steps(steps));
    // Closing report; the only place the run ends.
    task complete_run;
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_checks = n_checks + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bytes go back to back; strobe drops one edge after the last.
    task sendq(input logic [7:0] q[$]);
        foreach (q[i])
        begin
            @(posedge i_clk);
            i_wr <= 1'b1;
            i_wdata <= q[i];
        end
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    function logic sig(input integer w);
        case (w)
            0: sig = o_exec;
            1: sig = o_rd_valid;
            2: sig = o_interrupt;
            default: sig = !o_cmd_busy;
        endcase
    endfunction
    // Bounded wait; polling at falling edges avoids edge races.
    task await(input integer w);
        integer n;
        n = 0;
        @(negedge i_clk);
        while (sig(w) !== 1'b1 && n < 300)
        begin
            n = n + 1;
            @(negedge i_clk);
        end
        chk("wait", sig(w), 1'b1);
    endtask
    task takeq(input logic [7:0] q[$]);
        foreach (q[i])
        begin
            await(1);
            chk("result", o_rdata, q[i]);
            @(posedge i_clk) i_rd <= 1'b1;
            @(posedge i_clk) i_rd <= 1'b0;
        end
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            complete_run;
        end
    end
    initial
    begin
        rows[0] = 24'h450505;
        rows[1] = 24'hC50202;
        rows[2] = 24'h090707;
        rows[3] = 24'hC90000;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk("busy", o_cmd_busy, 1'b0);
        chk("irq", o_interrupt, 1'b0);
        chk("rdata", o_rdata, 8'h00);
        sendq('{8'hFF});
        takeq('{8'h80});
        await(3);
        sendq('{8'h03, 8'hA5, 8'h37});
        await(3);
        chk("step_rate", o_step_rate_time, 8'h0A);
        chk("unload", o_head_unload_time, 8'h05);
        chk("load", o_head_load_time, 8'h1B);
        chk("no_dma", o_no_dma_select, 8'h01);
        for (k = 0; k < 4; k = k + 1)
        begin
            sendq('{rows[k][23:16], rows[k][15:8], 8'h10, 8'h11,
                    8'h12, 8'h13, 8'h14, 8'h15, 8'h16});
            await(0);
            chk("req", o_data_req, 1'b1);
            chk("multi", o_multi_track_flag, rows[k][23]);
            chk("dens", o_density_select_flag, rows[k][22]);
            chk("del", o_deleted_mark, rows[k][19]);
            chk("drv", o_drive_sel, rows[k][9:8]);
            chk("head", o_head_select, rows[k][10]);
            sendq('{8'hA5});
            @(negedge i_clk);
            chk("stb", o_data_stb, 1'b1);
            chk("data", o_data_out, 8'hA5);
            sendq('{8'h5A});
            takeq('{rows[k][7:0], 8'h00, 8'h00,
                    8'h10, 8'h11, 8'h12, 8'h13});
            await(3);
        end
        quota <= 4'h0;
        sendq('{8'h4D, 8'h03, 8'h02, 8'h02, 8'h1B, 8'hE5});
        await(0);
        chk("fdrv", o_drive_sel, 8'h03);
        chk("fdens", o_density_select_flag, 1'b1);
        chk("fdel", o_deleted_mark, 1'b0);
        sendq('{8'h01, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00, 8'h02, 8'h02});
        takeq('{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        sendq('{8'h45, 8'h00, 8'h10});
        @(posedge i_clk) i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk("rbusy", o_cmd_busy, 1'b0);
        sendq('{8'h07, 8'h06});
        await(0);
        chk("rdrv", o_drive_sel, 8'h02);
        chk("rhead", o_head_select, 1'b0);
        chk("rreq", o_data_req, 1'b0);
        await(2);
        chk("steps", steps, 8'h03);
        sendq('{8'h08});
        await(1);
        sendq('{8'hFF});
        takeq('{8'h22, 8'h00});
        await(3);
        chk("irqclr", o_interrupt, 1'b0);
        sendq('{8'h08});
        takeq('{8'h80, 8'h00});
        await(3);
        complete_run;
    end
endmodule // fdcw_cmd_decoder_bench
